/* File: inc/supervisor_pkg.sv */
// constants shared by the supply supervisor and watchdog
package supervisor_pkg;
    // clock rate
    localparam real CLK_MHZ = 25.0; // clk_in rate in MHz
    localparam int TW = 22; // timer width, holds the longest window
    // times in their printed units
    localparam real STARTUP_HOLD_MS = 16.5; // hold after supply good
    localparam real IGNORE_WINDOW_MS = 16.0; // trigger edges ignored
    localparam real TRIGGER_WINDOW_MS = 96.0; // fixed trigger window
    localparam real FAULT_PULSE_MS = 8.0; // low pulse on watchdog fault
    localparam real DISABLE_FILTER_US = 500.0; // disable level dead time
    localparam real REACTION_DELAY_US = 10.0; // undervoltage reaction delay
    localparam real DIP_BLANKING_US = 7.0; // dips shorter than this are ignored
    // cycle counts derived from the times
    localparam int STARTUP_HOLD_CYC = int'(STARTUP_HOLD_MS * 1000.0 * CLK_MHZ);
    localparam int IGNORE_WINDOW_CYC = int'(IGNORE_WINDOW_MS * 1000.0 * CLK_MHZ);
    localparam int TRIGGER_WINDOW_CYC = int'(TRIGGER_WINDOW_MS * 1000.0 * CLK_MHZ);
    localparam int FAULT_PULSE_CYC = int'(FAULT_PULSE_MS * 1000.0 * CLK_MHZ);
    localparam int DISABLE_FILTER_CYC = int'(DISABLE_FILTER_US * CLK_MHZ);
    localparam int REACTION_DELAY_CYC = int'(REACTION_DELAY_US * CLK_MHZ);
    localparam int DIP_BLANKING_CYC = int'($ceil(DIP_BLANKING_US * CLK_MHZ));
    // synchroniser lanes
    localparam int SYN_GOOD = 0; // supply above rising level
    localparam int SYN_LOW = 1; // supply below falling level
    localparam int SYN_TRIG = 2; // trigger input level
    localparam int SYN_DIS = 3; // trigger input in disable band
    localparam int SYN_N = 4; // number of lanes
    localparam logic [SYN_N-1:0] SYN_RESET = 4'h0; // synchroniser reset value
    // watchdog states, one-hot
    typedef enum logic [4:0] {
        ST_HOLD = 5'h01, // output low, startup hold
        ST_IGNORE = 5'h02, // ignore window
        ST_TRIGGER = 5'h04, // trigger window
        ST_FAULT = 5'h08, // watchdog fault low pulse
        ST_DISABLED = 5'h10 // watchdog deactivated
    } wd_state_e;
endpackage : supervisor_pkg

/* File: rtl/supply_supervisor_watchdog.sv */
// supply supervisor with timeout watchdog on one combined fault output
`timescale 1ns/1ns
// Operation
// - hold output low 16.5 ms after supply good
// - good above rising level, fault below falling
// - undervoltage pulls low after reaction delay, blanks dips
// - ignore window starts at release, edges ignored
// - ignore window expiry opens trigger window
// - falling trigger edge restarts trigger window
// - no edge before expiry pulls output low
// - all timing from own clock only
// - undervoltage and watchdog share one low output
// - ignore window lasts 16 ms
// - trigger window fixed at 96 ms
// - watchdog fault low pulse lasts 8 ms
// - filtered disable level deactivates, leaving reactivates
module supply_supervisor_watchdog
    import supervisor_pkg::*;
#(
    parameter int STARTUP_CYC = STARTUP_HOLD_CYC, // startup hold cycles
    parameter int IGNORE_CYC = IGNORE_WINDOW_CYC, // ignore window cycles
    parameter int TRIGGER_CYC = TRIGGER_WINDOW_CYC, // trigger window cycles
    parameter int FAULT_CYC = FAULT_PULSE_CYC, // fault pulse cycles
    parameter int FILTER_CYC = DISABLE_FILTER_CYC // disable filter cycles
) (
    input wire logic clk_in, // 25 MHz internal oscillator clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic supply_good_in, // comparator: supply above rising level
    input wire logic supply_low_in, // comparator: supply below falling level
    input wire logic trigger_in, // trigger input level from controller
    input wire logic disable_level_in, // comparator: trigger input in disable band
    output logic combined_fault_n_out, // combined fault output level, low = fault
    output logic combined_fault_oe_out // high while the output pulls low
);
    localparam logic [TW-1:0] STARTUP_LIM = TW'(STARTUP_CYC); // sized limits
    localparam logic [TW-1:0] IGNORE_LIM = TW'(IGNORE_CYC);
    localparam logic [TW-1:0] TRIGGER_LIM = TW'(TRIGGER_CYC);
    localparam logic [TW-1:0] FAULT_LIM = TW'(FAULT_CYC);
    localparam logic [TW-1:0] FILTER_LIM = TW'(FILTER_CYC);
    localparam logic [TW-1:0] REACT_LIM = TW'(REACTION_DELAY_CYC);
    localparam int REACT_N = REACTION_DELAY_CYC; // helper bound for checks

    ////////////////////////////////////////////////////////////////
    // declarations
    logic [SYN_N-1:0] sync1_q; // first synchroniser stage, read by stage two only
    logic [SYN_N-1:0] sync2_q; // second synchroniser stage
    logic trig_prev_q; // trigger level one cycle back
    logic good_q; // supply judged good, with hysteresis
    logic good_d; // next supply judgement
    wd_state_e st_q; // watchdog state
    wd_state_e st_d; // next watchdog state
    logic fault_n_d; // next combined output level
    logic fall_edge; // falling trigger edge seen
    logic uv_fault; // qualified undervoltage
    logic tmr_done; // current window elapsed
    logic tmr_clr; // restart window timer
    logic tmr_run; // window timer counts
    logic [TW-1:0] tmr_lim; // window length for current state
    logic dis_mismatch; // disable level differs from current mode
    logic dis_done; // disable level change held for filter time
    logic retrig; // trigger window restart
    logic dis_flip; // entering or leaving the disabled mode this cycle

    ////////////////////////////////////////////////////////////////
    // two-flop synchronisers on all pin inputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= SYN_RESET;
            sync2_q <= SYN_RESET;
            trig_prev_q <= 1'b0;
        end else begin
            sync1_q <= {disable_level_in, trigger_in, supply_low_in, supply_good_in};
            sync2_q <= sync1_q;
            trig_prev_q <= sync2_q[SYN_TRIG];
        end
    end

    // only high-to-low counts; a trigger line parked in the disable band is not an edge
    assign fall_edge = trig_prev_q && !sync2_q[SYN_TRIG] && !sync2_q[SYN_DIS];

    ////////////////////////////////////////////////////////////////
    // undervoltage qualification: low must persist for the reaction delay,
    // which is longer than the blanking time, so short dips never reach the fsm
    window_timer #(.W(TW)) u_uv_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!sync2_q[SYN_LOW]),
        .run_in(sync2_q[SYN_LOW]),
        .limit_in(REACT_LIM),
        .expired_out(uv_fault)
    );

    // hysteresis: set above rising level, cleared only by a qualified fall
    assign good_d = uv_fault ? 1'b0 : (sync2_q[SYN_GOOD] ? 1'b1 : good_q);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            good_q <= 1'b0;
        end else begin
            good_q <= good_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // disable band filter: any change of mode needs the level held steady
    assign dis_mismatch = sync2_q[SYN_DIS] ^ (st_q == ST_DISABLED);
    // the filter flag is registered, so it would still read expired on the first cycle
    // of the new mode and bounce straight back; a mode change restarts the filter
    assign dis_flip = (st_d == ST_DISABLED) != (st_q == ST_DISABLED);

    window_timer #(.W(TW)) u_dis_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!dis_mismatch || (st_q == ST_HOLD) || dis_flip),
        .run_in(dis_mismatch),
        .limit_in(FILTER_LIM),
        .expired_out(dis_done)
    );

    ////////////////////////////////////////////////////////////////
    // window timer, one counter shared by all states
    always_comb begin
        case (st_q)
            ST_HOLD: tmr_lim = STARTUP_LIM;
            ST_IGNORE: tmr_lim = IGNORE_LIM;
            ST_TRIGGER: tmr_lim = TRIGGER_LIM;
            ST_FAULT: tmr_lim = FAULT_LIM;
            default: tmr_lim = TRIGGER_LIM;
        endcase
    end

    assign retrig = (st_q == ST_TRIGGER) && fall_edge && (st_d == ST_TRIGGER);
    assign tmr_clr = (st_d != st_q) || retrig;
    // the hold only counts while the supply is good; it restarts on every fall
    assign tmr_run = (st_q != ST_HOLD) || good_q;

    // timebase is clk_in alone; the trigger input never clocks anything
    window_timer #(.W(TW)) u_win_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(tmr_clr || ((st_q == ST_HOLD) && !good_q)),
        .run_in(tmr_run),
        .limit_in(tmr_lim),
        .expired_out(tmr_done)
    );

    ////////////////////////////////////////////////////////////////
    // watchdog state machine; undervoltage overrides everything
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_HOLD: begin
                if (good_q && tmr_done) begin
                    st_d = ST_IGNORE; // release starts the ignore window
                end
            end
            ST_IGNORE: begin
                if (dis_done) begin
                    st_d = ST_DISABLED;
                end else if (tmr_done) begin
                    st_d = ST_TRIGGER; // edges before this point are dropped
                end
            end
            ST_TRIGGER: begin
                if (dis_done) begin
                    st_d = ST_DISABLED;
                end else if (tmr_done && !fall_edge) begin
                    st_d = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (tmr_done) begin
                    st_d = ST_IGNORE;
                end
            end
            ST_DISABLED: begin
                if (dis_done) begin
                    st_d = ST_IGNORE; // leaving the band restarts supervision
                end
            end
            default: st_d = ST_HOLD;
        endcase
        if (uv_fault || !good_q) begin
            st_d = ST_HOLD;
        end
    end

    // both causes drive the one output low
    assign fault_n_d = (st_d != ST_HOLD) && (st_d != ST_FAULT);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= ST_HOLD;
            combined_fault_n_out <= 1'b0;
            combined_fault_oe_out <= 1'b1;
        end else begin
            st_q <= st_d;
            combined_fault_n_out <= fault_n_d;
            combined_fault_oe_out <= !fault_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    logic [TW-1:0] low_run_q; // consecutive synchronised low cycles, helper only

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_run_q <= '0;
        end else begin
            low_run_q <= sync2_q[SYN_LOW] ? low_run_q + 1'b1 : '0;
        end
    end

    sequence s_timeout;
        (st_q == ST_TRIGGER) && tmr_done && !fall_edge && !uv_fault && good_q && !dis_done;
    endsequence

    sequence s_pulled_low;
        (st_q == ST_FAULT) ##1 !combined_fault_n_out;
    endsequence

    a_hold_output_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_HOLD) |-> !combined_fault_n_out)
        else $error("output high during hold");
    a_hold_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ($past(st_q) == ST_HOLD) && (st_q == ST_IGNORE) |-> $past(tmr_done) && combined_fault_n_out)
        else $error("hold ended early");
    a_dip_blanked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(uv_fault) |-> (low_run_q >= REACT_N))
        else $error("short dip caused reset");
    a_uv_reaction: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(uv_fault) |=> (st_q == ST_HOLD) ##1 !combined_fault_n_out)
        else $error("undervoltage not signalled");
    a_ignore_no_trig: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_IGNORE) && !tmr_done && !dis_done && !uv_fault && good_q |=> (st_q == ST_IGNORE))
        else $error("ignore window left early");
    a_trig_window_open: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_IGNORE) && tmr_done && !dis_done && !uv_fault && good_q |=> (st_q == ST_TRIGGER))
        else $error("trigger window not opened");
    a_retrigger_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_TRIGGER) && fall_edge && !dis_done && !uv_fault && good_q
        |=> (st_q == ST_TRIGGER) ##1 !tmr_done)
        else $error("falling edge did not restart window");
    a_timeout_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_timeout |=> s_pulled_low)
        else $error("missed trigger not signalled");
    a_fault_recover: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_FAULT) && tmr_done && !uv_fault && good_q |=> (st_q == ST_IGNORE) ##1 combined_fault_n_out)
        else $error("no recovery after fault pulse");
    a_uv_clears_wd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !good_q |=> (st_q == ST_HOLD))
        else $error("watchdog ran during undervoltage");
    a_disable_enter: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ((st_q == ST_IGNORE) || (st_q == ST_TRIGGER)) && dis_done && !uv_fault && good_q
        |=> (st_q == ST_DISABLED) ##1 combined_fault_n_out)
        else $error("disable level not honoured");
    a_disable_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st_q == ST_DISABLED) && ($past(st_q) != ST_DISABLED) && sync2_q[SYN_DIS] && good_q
        && !uv_fault |=> (st_q == ST_DISABLED))
        else $error("disable mode left while level held");
    a_oe_matches: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        combined_fault_oe_out == !combined_fault_n_out)
        else $error("enable and level disagree");
endmodule : supply_supervisor_watchdog

/* File: rtl/window_timer.sv */
// up counter that flags when a programmed number of cycles has elapsed
`timescale 1ns/1ns
module window_timer #(
    parameter int W = 22 // counter width
) (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic clear_in, // restart from zero
    input wire logic run_in, // count this cycle
    input wire logic [W-1:0] limit_in, // cycles to elapse
    output logic expired_out // high once limit cycles have run
);
    logic [W-1:0] count_q; // elapsed cycles
    logic [W-1:0] count_d; // next elapsed cycles
    logic at_limit; // count has reached the limit

    assign at_limit = (count_q >= limit_in);
    // clear wins over counting; the count saturates at the limit
    assign count_d = clear_in ? '0 : ((run_in && !at_limit) ? count_q + 1'b1 : count_q);

    ////////////////////////////////////////////////////////////////
    // counter and registered flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= '0;
            expired_out <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_out <= (count_d >= limit_in);
        end
    end
endmodule : window_timer

/* File: tb/mcu_model.sv */
// behavioural controller that services the trigger input at a chosen period
`timescale 1ns/1ns
module mcu_model (
    input wire logic clk_in, // supervisor clock, used as a time base only
    input wire logic run_n_in, // controller held in reset while low
    input wire logic kick_en_in, // firmware services the guard timer
    input wire logic [7:0] period_in, // cycles between falling edges
    output logic trigger_out // trigger input level
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] tick_q; // cycles since the last falling edge
    // square wave, falling edge once per period; idle low like the pull-down
    always_ff @(posedge clk_in) begin
        if (!run_n_in || !kick_en_in) begin
            // a controller in reset leaves the pin to its pull-down
            tick_q <= 8'h00;
            trigger_out <= 1'b0;
        end else if (tick_q >= period_in - 8'h01) begin
            // falling edge once each period drives the trigger output low
            tick_q <= 8'h00;
            trigger_out <= 1'b0;
        end else begin
            tick_q <= tick_q + 8'h01;
            // rising half way, so each edge is separated by many cycles
            if (tick_q == (period_in >> 1)) begin
                trigger_out <= 1'b1;
            end
        end
    end
endmodule : mcu_model

/* File: tb/supply_supervisor_watchdog_tb.sv */
// self-checking bench for the supply supervisor and guard timer
`timescale 1ns/1ns
module supply_supervisor_watchdog_tb;
    // shortened windows; undervoltage reaction stays at its real count
    localparam int ST = 40, IG = 30, TR = 60, FL = 20, FI = 10, RE = 250;
    logic clk_in, rst_n_in, supply_good, supply_low, man_trig, dis_lvl, kick_en;
    logic [7:0] kick_per; // controller service period
    logic mcu_trig; // trigger from the controller model
    logic fault_n, fault_oe; // combined output and its pull-down enable
    wire logic trig = kick_en ? mcu_trig : man_trig; // who owns the trigger pin
    int error_cnt, n_checks, n;
    ////////////////////////////////////////////////////////////////////////
    supply_supervisor_watchdog #(.STARTUP_CYC(ST), .IGNORE_CYC(IG), .TRIGGER_CYC(TR),
        .FAULT_CYC(FL), .FILTER_CYC(FI)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .supply_good_in(supply_good), .supply_low_in(supply_low), .trigger_in(trig),
        .disable_level_in(dis_lvl), .combined_fault_n_out(fault_n),
        .combined_fault_oe_out(fault_oe));
    mcu_model i_mcu (.clk_in(clk_in), .run_n_in(fault_n), .kick_en_in(kick_en),
        .period_in(kick_per), .trigger_out(mcu_trig));
    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // counts and verdict, the single place the run ends
    task end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // a measured span must fall inside a band around the nominal count
    task check_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_rng
    // output level, with the enable always its inverse
    task check_lvl(input logic exp);
        n_checks++;
        if (fault_n !== exp || fault_oe !== !exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, {fault_n, fault_oe}, {exp, !exp});
        end
    endtask : check_lvl
    // cycles the output stays at lvl, sampled on falling edges, capped
    task span(input logic lvl, input int cap, output int cnt);
        cnt = 0;
        @(negedge clk_in);
        while (fault_n === lvl && cnt < cap) begin
            cnt++;
            @(negedge clk_in);
        end
    endtask : span
    // wait for the next release of the output
    task wait_rise;
        span(1'b1, 2000, n);
        span(1'b0, 2000, n);
        check_rng(n, 0, FL + 4);
    endtask : wait_rise
    ////////////////////////////////////////////////////////////////////////
    // reset state and no release while the supply is not good
    task t_reset;
        @(negedge clk_in);
        check_lvl(1'b0);
        repeat (100) @(negedge clk_in);
        check_lvl(1'b0);
    endtask : t_reset
    // startup hold counted from supply good
    task t_startup;
        @(posedge clk_in) supply_good <= 1'b1;
        span(1'b0, 2000, n);
        check_rng(n, ST, ST + 6);
    endtask : t_startup
    // falling edge in ignore and a rising edge in trigger window do not help
    task t_no_kick;
        n = 0;
        while (fault_n === 1'b1 && n < 2000) begin
            @(posedge clk_in);
            if (n == 2) man_trig <= 1'b1;
            if (n == 10) man_trig <= 1'b0; // edge inside the ignore window
            if (n == 50) man_trig <= 1'b1; // rising edge only
            @(negedge clk_in);
            n++;
        end
        check_rng(n, IG + TR, IG + TR + 6);
        span(1'b0, 2000, n);
        check_rng(n, FL, FL + 4);
        span(1'b1, 2000, n);
        check_rng(n, IG + TR, IG + TR + 6);
    endtask : t_no_kick
    // controller serving at a prompt and a slow period
    task t_kick(input logic [7:0] per, input int lo, input int hi);
        @(posedge clk_in) kick_per <= per;
        kick_en <= 1'b1;
        wait_rise;
        span(1'b1, 400, n);
        check_rng(n, lo, hi);
        @(posedge clk_in) kick_en <= 1'b0;
    endtask : t_kick
    // disable level parks the guard timer, leaving it restarts with ignore
    task t_disable;
        wait_rise;
        repeat (5) @(posedge clk_in);
        dis_lvl <= 1'b1;
        span(1'b1, 300, n);
        check_rng(n, 300, 300);
        @(posedge clk_in) dis_lvl <= 1'b0;
        span(1'b1, 2000, n);
        check_rng(n, FI + IG + TR, FI + IG + TR + 10);
    endtask : t_disable
    // short dip blanked, long dip resets, hold restarts after recovery
    task t_uv;
        @(posedge clk_in) kick_per <= 8'd40;
        kick_en <= 1'b1;
        wait_rise;
        repeat (20) @(posedge clk_in);
        // short dip, with the rising comparator dropping too: hysteresis keeps good
        supply_low <= 1'b1;
        supply_good <= 1'b0;
        repeat (100) @(posedge clk_in);
        supply_low <= 1'b0;
        supply_good <= 1'b1;
        repeat (10) @(negedge clk_in);
        check_lvl(1'b1);
        @(posedge clk_in) supply_low <= 1'b1;
        supply_good <= 1'b0;
        span(1'b1, 2000, n);
        check_rng(n, RE, RE + 8);
        repeat (300) @(negedge clk_in);
        check_lvl(1'b0);
        @(posedge clk_in) supply_low <= 1'b0;
        supply_good <= 1'b1;
        span(1'b0, 2000, n);
        check_rng(n, ST, ST + 6);
        @(posedge clk_in) kick_en <= 1'b0;
    endtask : t_uv
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        error_cnt = 0;
        n_checks = 0;
        rst_n_in = 1'b0;
        supply_good = 1'b0;
        supply_low = 1'b0;
        man_trig = 1'b0;
        dis_lvl = 1'b0;
        kick_en = 1'b0;
        kick_per = 8'd40;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_startup;
        t_no_kick;
        t_kick(8'd40, 400, 400);
        t_kick(8'd55, 400, 400);
        t_kick(8'd80, 100, 200);
        t_disable;
        t_uv;
        end_sim;
    end
    // hang guard, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        end_sim;
    end
endmodule : supply_supervisor_watchdog_tb
